/* File: logic/outcfg_consts.vh */
// Constants for the output configuration register bank.
`ifndef OUTCFG_CONSTS_VH
`define OUTCFG_CONSTS_VH

// ----------------------------------------------------------------------------
// Bus widths and responses
// ----------------------------------------------------------------------------
`define AXI_ADDR_W        12
`define AXI_DATA_W        32
`define REG_W             8
`define IDX_W             10
`define IDX_LSB           2
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ----------------------------------------------------------------------------
// Register indexes; byte address is four times the index
// ----------------------------------------------------------------------------
`define IDX_SYSREF_GATE   10'h06A
`define IDX_SWING         10'h06F
`define IDX_LANE_AB_HI    10'h071
`define IDX_LANE_B_LO     10'h072
`define IDX_LANE_CD_HI    10'h093
`define IDX_LANE_D_LO     10'h094
`define IDX_CD_MODE       10'h0AE
`define IDX_TRIM_LOAD     10'h0B7
`define IDX_CFG_STATUS    10'h0C0

// ----------------------------------------------------------------------------
// Writable bit masks; all other positions store and read zero
// ----------------------------------------------------------------------------
`define MASK_SYSREF_GATE  8'h02
`define MASK_SWING        8'h70
`define MASK_LANE_HI      8'hFF
`define MASK_LANE_LO      8'h0F
`define MASK_CD_MODE      8'h0F
`define MASK_TRIM_LOAD    8'h01
`define REG_RESET         8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SYSREF_MASK_BIT   1
`define TRIM_LOAD_BIT     0
`define SWING_MSB         6
`define SWING_LSB         4
`define MODE_MSB          3
`define MODE_LSB          0
`define DEEMPH_MSB        5
`define DEEMPH_LSB        0
`define UPPER_MSB         7
`define UPPER_LSB         6
`define LOWER_MSB         3
`define LOWER_LSB         0

// ----------------------------------------------------------------------------
// Down-conversion mode codes
// ----------------------------------------------------------------------------
`define MODE_GAP          4'h5
`define MODE_LAST         4'h8

`endif

/* File: logic/sysref_gate.v */
// Registered SYSREF gate with rising-edge pulse.
`timescale 1ns/100ps
`include "outcfg_consts.vh"

module sysref_gate (
  // Clock and reset
  input  wire clk,
  input  wire reset_n,
  // Timing reference in and mask
  input  wire sysref_in,
  input  wire mask,
  // Gated reference out
  output reg  sysref_out_r,
  output reg  sysref_edge_r
);

  // Passes the reference only while unmasked, and flags its rising edge.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sysref_out_r  <= 1'b0;
      sysref_edge_r <= 1'b0;
    end else begin
      sysref_out_r  <= sysref_in & ~mask;
      sysref_edge_r <= sysref_in & ~mask & ~sysref_out_r;
    end
  end

endmodule // sysref_gate

/* File: logic/adc_output_config_regs.v */
// AXI4-Lite register bank for output and down-conversion configuration.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "outcfg_consts.vh"

// Functional notes
// [R1] Pair C/D down-conversion mode is bits 3..0; codes 0-4 and 6-8 defined.
// [R2] Unnamed bits are written zero by software and always read back zero.
// [R3] Writing bit 0 of the trim-load register loads trims; bits 7..1 unused.
// [R4] Timing-reference mask bit 1: zero passes SYSREF, one blocks it.
// [R5] Swing select in bits 6..4 picks one of eight output swing levels.
// [R6] Lane A de-emphasis is bits 5..0, codes 0,1,3,7,15,31,63.
// [R7] Lane B de-emphasis upper two bits at 7..6, lower four in next register.
// [R8] Lane C de-emphasis is bits 5..0 sharing register with lane D upper part.
// [R9] Lane D de-emphasis upper two bits at 7..6, lower four in next register.
// [R10] Software uses only the seven listed de-emphasis codes.
// [R11] After reset every field reads zero.
// [R12] Software writes trim-load one then zero; the bit does not self-clear.
module adc_output_config_regs (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // AXI4-Lite write address channel
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data channel
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response channel
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address channel
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data channel
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Timing reference
  input  wire        sysref_in,
  output wire        sysref_gated,
  output wire        sysref_edge,
  // Configuration outputs
  output reg  [3:0]  pair_cd_downconv_mode,
  output reg         timing_ref_input_mask,
  output reg  [2:0]  serial_output_swing_sel,
  output reg  [5:0]  lane_a_deemphasis,
  output reg  [5:0]  lane_b_deemphasis,
  output reg  [5:0]  lane_c_deemphasis,
  output reg  [5:0]  lane_d_deemphasis,
  output reg         trim_load_trigger,
  output reg         trim_load_pulse
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------

  // True for a de-emphasis code that is all ones from bit 0 upward, or zero.
  function deemph_code_ok;
    input [5:0] code;
    begin
      deemph_code_ok = ((code & (code + 6'h01)) == 6'h00);
    end
  endfunction

  // Converts a byte address to a register index.
  function [`IDX_W-1:0] addr_to_idx;
    input [`AXI_ADDR_W-1:0] addr;
    begin
      addr_to_idx = addr[`AXI_ADDR_W-1:`IDX_LSB];
    end
  endfunction

  // True for any index that the bank answers.
  function idx_mapped;
    input [`IDX_W-1:0] idx;
    begin
      case (idx)
        `IDX_SYSREF_GATE, `IDX_SWING, `IDX_LANE_AB_HI, `IDX_LANE_B_LO,
        `IDX_LANE_CD_HI, `IDX_LANE_D_LO, `IDX_CD_MODE, `IDX_TRIM_LOAD,
        `IDX_CFG_STATUS: idx_mapped = 1'b1;
        default:         idx_mapped = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg  [7:0]        sysref_gate_control_r;
  reg  [7:0]        serial_swing_control_r;
  reg  [7:0]        lane_ab_deemphasis_high_r;
  reg  [7:0]        lane_b_deemphasis_low_r;
  reg  [7:0]        lane_cd_deemphasis_high_r;
  reg  [7:0]        lane_d_deemphasis_low_r;
  reg  [7:0]        pair_cd_filter_mode_r;
  reg  [7:0]        trim_load_control_r;
  reg  [`IDX_W-1:0] wr_idx_r;
  reg  [7:0]        wr_data_r;
  reg               wr_lane0_r;
  reg               aw_held_r;
  reg               w_held_r;
  wire              do_write;
  wire [23:0]       lane_codes;
  wire [3:0]        lane_bad;
  wire              mode_bad;
  reg  [7:0]        rd_byte;

  // --------------------------------------------------------------------------
  // Write channel handshake
  // --------------------------------------------------------------------------

  // A write is committed once address and data are both held and no response waits.
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

  // Address and data are taken independently, then one response follows both.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      wr_idx_r      <= {`IDX_W{1'b0}};
      wr_data_r     <= `REG_RESET;
      wr_lane0_r    <= 1'b0;
    end else begin
      // Address capture.
      if (s_axi_awvalid && s_axi_awready) begin
        wr_idx_r      <= addr_to_idx(s_axi_awaddr);
        aw_held_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!aw_held_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      // Data capture; only byte lane 0 carries register bits.
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_r    <= s_axi_wdata[7:0];
        wr_lane0_r   <= s_axi_wstrb[0];
        w_held_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!w_held_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      // Response once both halves are in.
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= idx_mapped(wr_idx_r) ? `RESP_OKAY : `RESP_SLVERR;
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------

  // Stores only named field bits, so unnamed positions stay zero.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sysref_gate_control_r     <= `REG_RESET; // [R11]
      serial_swing_control_r    <= `REG_RESET;
      lane_ab_deemphasis_high_r <= `REG_RESET;
      lane_b_deemphasis_low_r   <= `REG_RESET;
      lane_cd_deemphasis_high_r <= `REG_RESET;
      lane_d_deemphasis_low_r   <= `REG_RESET;
      pair_cd_filter_mode_r     <= `REG_RESET;
      trim_load_control_r       <= `REG_RESET;
    end else if (do_write && wr_lane0_r) begin
      case (wr_idx_r)
        `IDX_SYSREF_GATE: sysref_gate_control_r     <= wr_data_r & `MASK_SYSREF_GATE; // [R2]
        `IDX_SWING:       serial_swing_control_r    <= wr_data_r & `MASK_SWING;
        `IDX_LANE_AB_HI:  lane_ab_deemphasis_high_r <= wr_data_r & `MASK_LANE_HI;
        `IDX_LANE_B_LO:   lane_b_deemphasis_low_r   <= wr_data_r & `MASK_LANE_LO;
        `IDX_LANE_CD_HI:  lane_cd_deemphasis_high_r <= wr_data_r & `MASK_LANE_HI;
        `IDX_LANE_D_LO:   lane_d_deemphasis_low_r   <= wr_data_r & `MASK_LANE_LO;
        `IDX_CD_MODE:     pair_cd_filter_mode_r     <= wr_data_r & `MASK_CD_MODE;
        `IDX_TRIM_LOAD:   trim_load_control_r       <= wr_data_r & `MASK_TRIM_LOAD; // [R3]
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Field assembly
  // --------------------------------------------------------------------------

  // Split lanes join their upper and lower parts; lanes A and C are whole.
  assign lane_codes[5:0]   = lane_ab_deemphasis_high_r[`DEEMPH_MSB:`DEEMPH_LSB]; // [R6]
  assign lane_codes[11:6]  = {lane_ab_deemphasis_high_r[`UPPER_MSB:`UPPER_LSB],
                              lane_b_deemphasis_low_r[`LOWER_MSB:`LOWER_LSB]}; // [R7]
  assign lane_codes[17:12] = lane_cd_deemphasis_high_r[`DEEMPH_MSB:`DEEMPH_LSB]; // [R8]
  assign lane_codes[23:18] = {lane_cd_deemphasis_high_r[`UPPER_MSB:`UPPER_LSB],
                              lane_d_deemphasis_low_r[`LOWER_MSB:`LOWER_LSB]}; // [R9]

  // Flags a lane whose code lies outside the seven allowed ones.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane_chk
      assign lane_bad[g] = ~deemph_code_ok(lane_codes[g*6 +: 6]); // [R10]
    end
  endgenerate

  // Flags a mode code with no defined meaning.
  assign mode_bad = (pair_cd_filter_mode_r[`MODE_MSB:`MODE_LSB] == `MODE_GAP) ||
                    (pair_cd_filter_mode_r[`MODE_MSB:`MODE_LSB] > `MODE_LAST); // [R1]

  // Drives the configuration outputs from flip-flops.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pair_cd_downconv_mode   <= 4'h0;
      timing_ref_input_mask   <= 1'b0;
      serial_output_swing_sel <= 3'h0;
      lane_a_deemphasis       <= 6'h00;
      lane_b_deemphasis       <= 6'h00;
      lane_c_deemphasis       <= 6'h00;
      lane_d_deemphasis       <= 6'h00;
      trim_load_trigger       <= 1'b0;
    end else begin
      pair_cd_downconv_mode   <= pair_cd_filter_mode_r[`MODE_MSB:`MODE_LSB]; // [R1]
      timing_ref_input_mask   <= sysref_gate_control_r[`SYSREF_MASK_BIT]; // [R4]
      serial_output_swing_sel <= serial_swing_control_r[`SWING_MSB:`SWING_LSB]; // [R5]
      lane_a_deemphasis       <= lane_codes[5:0];
      lane_b_deemphasis       <= lane_codes[11:6];
      lane_c_deemphasis       <= lane_codes[17:12];
      lane_d_deemphasis       <= lane_codes[23:18];
      trim_load_trigger       <= trim_load_control_r[`TRIM_LOAD_BIT]; // [R12]
    end
  end

  // Pulses once for every write that puts a one in the trim-load bit.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_load_pulse <= 1'b0;
    end else begin
      trim_load_pulse <= do_write & wr_lane0_r & (wr_idx_r == `IDX_TRIM_LOAD) &
                         wr_data_r[`TRIM_LOAD_BIT]; // [R3]
    end
  end

  // --------------------------------------------------------------------------
  // Timing reference gate
  // --------------------------------------------------------------------------

  // The stored mask bit blocks the reference inside the gate.
  sysref_gate u_sysref_gate (
    .clk           (clk),
    .reset_n       (reset_n),
    .sysref_in     (sysref_in),
    .mask          (sysref_gate_control_r[`SYSREF_MASK_BIT]),
    .sysref_out_r  (sysref_gated),
    .sysref_edge_r (sysref_edge)
  ); // [R4]

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------

  // Selects the addressed register byte; unmapped addresses read zero.
  always @* begin
    case (addr_to_idx(s_axi_araddr))
      `IDX_SYSREF_GATE: rd_byte = sysref_gate_control_r;
      `IDX_SWING:       rd_byte = serial_swing_control_r;
      `IDX_LANE_AB_HI:  rd_byte = lane_ab_deemphasis_high_r;
      `IDX_LANE_B_LO:   rd_byte = lane_b_deemphasis_low_r;
      `IDX_LANE_CD_HI:  rd_byte = lane_cd_deemphasis_high_r;
      `IDX_LANE_D_LO:   rd_byte = lane_d_deemphasis_low_r;
      `IDX_CD_MODE:     rd_byte = pair_cd_filter_mode_r;
      `IDX_TRIM_LOAD:   rd_byte = trim_load_control_r;
      `IDX_CFG_STATUS:  rd_byte = {3'h0, mode_bad, lane_bad};
      default:          rd_byte = `REG_RESET;
    endcase
  end

  // One read at a time; data and response are held until rready.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte}; // [R2]
        s_axi_rresp   <= idx_mapped(addr_to_idx(s_axi_araddr)) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // adc_output_config_regs

/* File: testbench/outcfg_checker.sv */
// Port-level assertions for the output configuration register bank.
`timescale 1ns/100ps

module outcfg_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Timing reference
  input wire logic       sysref_in,
  input wire logic       sysref_gated,
  input wire logic       sysref_edge,
  // Configuration fields
  input wire logic       timing_ref_input_mask,
  input wire logic       trim_load_trigger,
  input wire logic       trim_load_pulse,
  input wire logic [5:0] lane_a_deemphasis,
  input wire logic [5:0] lane_d_deemphasis,
  input wire logic [3:0] pair_cd_downconv_mode,
  input wire logic [2:0] serial_output_swing_sel
);
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // The gated reference is the delayed input, held low while masked.
  a_ref_gating: assert property ($past(reset_n) |-> sysref_gated == ($past(sysref_in) && !timing_ref_input_mask))
    else $error("Gated reference does not follow input and mask.");
  a_ref_edge: assert property ($past(reset_n) |-> sysref_edge == (sysref_gated && !$past(sysref_gated)))
    else $error("Reference edge pulse misplaced.");
  // A load strobe is always followed one cycle later by the trigger set, and lasts one cycle.
  a_trim_strobe: assert property (trim_load_pulse |=> trim_load_trigger && !trim_load_pulse)
    else $error("Trim load strobe malformed.");
  // While reset is held lanes A and D, mode, swing, mask and trigger read zero.
  a_reset_zero: assert property (disable iff (1'b0) !reset_n |-> {lane_a_deemphasis, lane_d_deemphasis,
      pair_cd_downconv_mode, serial_output_swing_sel, timing_ref_input_mask, trim_load_trigger} == 22'h000000)
    else $error("Field not zero during reset.");
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Read data upper bits not zero.");
  // Bus answers and their holding.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write response late.");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before acceptance.");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("Read data late.");
  a_data_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped before acceptance.");
endmodule // outcfg_checker

bind adc_output_config_regs outcfg_checker i_outcfg_checker (.clk(clk), .reset_n(reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sysref_in(sysref_in), .sysref_gated(sysref_gated),
  .sysref_edge(sysref_edge), .timing_ref_input_mask(timing_ref_input_mask), .trim_load_trigger(trim_load_trigger),
  .trim_load_pulse(trim_load_pulse), .lane_a_deemphasis(lane_a_deemphasis), .lane_d_deemphasis(lane_d_deemphasis),
  .pair_cd_downconv_mode(pair_cd_downconv_mode), .serial_output_swing_sel(serial_output_swing_sel));

/* File: testbench/tb.sv */
// Self-checking bench for the output configuration register bank.
`timescale 1ns/100ps
`include "outcfg_consts.vh"

module tb;
  // ---------------------------------------------------------------------
  // Signals and bookkeeping
  // ---------------------------------------------------------------------
  logic        clk, reset_n, awvalid, wvalid, bready, arvalid, rready, sysref_in;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  wire         gated, ref_edge, mask, trig, tpulse;
  wire  [3:0]  mode;
  wire  [2:0]  swing;
  wire  [5:0]  la, lb, lc, ld;
  logic [33:0] rq[$];
  logic [33:0] rexp;
  logic [1:0]  bq[$];
  logic [9:0]  idx[8] = '{`IDX_SYSREF_GATE, `IDX_SWING, `IDX_LANE_AB_HI, `IDX_LANE_B_LO, `IDX_LANE_CD_HI,
                         `IDX_LANE_D_LO, `IDX_CD_MODE, `IDX_TRIM_LOAD};
  logic [7:0]  msk[8] = '{8'h02, 8'h70, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'h01};
  logic [5:0]  emp[7] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F};
  logic [5:0]  ea, eb, ec, ed;
  int          fail_count, compares, cyc, pulses, gated_n, edge_n;

  adc_output_config_regs i_adc_output_config_regs (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sysref_in(sysref_in), .sysref_gated(gated), .sysref_edge(ref_edge), .pair_cd_downconv_mode(mode),
    .timing_ref_input_mask(mask), .serial_output_swing_sel(swing), .lane_a_deemphasis(la),
    .lane_b_deemphasis(lb), .lane_c_deemphasis(lc), .lane_d_deemphasis(ld), .trim_load_trigger(trig),
    .trim_load_pulse(tpulse));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  // Compares one value and counts the result.
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Register index to byte address.
  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  // One write; address and data offered together, response accepted after a random stall.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad_ok, wd_ok;
    bq.push_back(er);
    ad_ok = 1'b0;
    wd_ok = 1'b0;
    awaddr  <= a;
    wdata   <= {24'($urandom), d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ad_ok && wd_ok)) begin
      @(posedge clk);
      ad_ok = ad_ok | (awvalid & awready);
      wd_ok = wd_ok | (wvalid & wready);
      awvalid <= ~ad_ok;
      wvalid  <= ~wd_ok;
    end
    repeat ($urandom % 3) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  // One read; the expected byte and response are queued for the monitor.
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    rq.push_back({er, 24'h000000, d});
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    repeat ($urandom % 3) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // Monitor: matches each response with the oldest note, counts events, cuts a hang.
  always @(posedge clk) begin
    if (bvalid && bready)
      check("bresp", 32'(bq.pop_front()), 32'(bresp));
    if (rvalid && rready) begin
      rexp = rq.pop_front();
      check("rdata", rexp[31:0], rdata);
      check("rresp", 32'(rexp[33:32]), 32'(rresp));
    end
    pulses  += int'(tpulse);
    gated_n += int'(gated);
    edge_n  += int'(ref_edge);
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      conclude();
    end
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hFA63));
    {reset_n, awvalid, wvalid, bready, arvalid, rready, sysref_in} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = {12'h000, 12'h000, 32'h00000000, 4'hF};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (idx[i]) rd(ad(idx[i]), 8'h00, `RESP_OKAY);
    foreach (idx[i]) begin
      wr(ad(idx[i]), 8'hFF, `RESP_OKAY);
      rd(ad(idx[i]), msk[i], `RESP_OKAY);
    end
    check("lanes_ff", {la, lb, lc, ld}, 24'hFFFFFF);
    check("ctrl_ff", {mode, swing, mask, trig}, {4'hF, 3'h7, 2'h3});
    // Mode code 0xF is undefined while every lane holds a listed code.
    rd(ad(`IDX_CFG_STATUS), 8'h10, `RESP_OKAY);
    // Masked reference: nothing passes.
    gated_n = 0;
    repeat (20) begin
      @(posedge clk);
      sysref_in <= 1'($urandom);
    end
    sysref_in <= 1'b0;
    check("gated_masked", gated_n, 0);
    wr(ad(`IDX_SYSREF_GATE), 8'h00, `RESP_OKAY);
    gated_n = 0;
    edge_n = 0;
    repeat (3) @(posedge clk) sysref_in <= 1'b1;
    @(posedge clk) sysref_in <= 1'b0;
    repeat (3) @(posedge clk);
    check("gated_open", gated_n, 3);
    check("edges", edge_n, 1);
    // Each write of one loads trims; software then writes it back to zero.
    wr(ad(`IDX_TRIM_LOAD), 8'h01, `RESP_OKAY);
    wr(ad(`IDX_TRIM_LOAD), 8'h01, `RESP_OKAY);
    wr(ad(`IDX_TRIM_LOAD), 8'h00, `RESP_OKAY);
    rd(ad(`IDX_TRIM_LOAD), 8'h00, `RESP_OKAY);
    check("trim_pulses", pulses, 3);
    check("trim_level", 32'(trig), 0);
    // Every defined down-conversion mode.
    for (int c = 0; c <= 8; c++) begin
      if (c == 5)
        continue;
      wr(ad(`IDX_CD_MODE), 8'(c), `RESP_OKAY);
      rd(ad(`IDX_CD_MODE), 8'(c), `RESP_OKAY);
      check("mode", 32'(mode), c);
    end
    // Every swing code.
    for (int c = 0; c < 8; c++) begin
      wr(ad(`IDX_SWING), 8'(c << 4), `RESP_OKAY);
      rd(ad(`IDX_SWING), 8'(c << 4), `RESP_OKAY);
      check("swing", 32'(swing), c);
    end
    // Listed de-emphasis codes only, split lanes joined.
    for (int i = 0; i < 7; i++) begin
      ea = emp[i];
      eb = emp[$urandom % 7];
      ec = emp[(i + 3) % 7];
      ed = emp[$urandom % 7];
      wr(ad(`IDX_LANE_AB_HI), {eb[5:4], ea}, `RESP_OKAY);
      wr(ad(`IDX_LANE_B_LO), {4'h0, eb[3:0]}, `RESP_OKAY);
      wr(ad(`IDX_LANE_CD_HI), {ed[5:4], ec}, `RESP_OKAY);
      wr(ad(`IDX_LANE_D_LO), {4'h0, ed[3:0]}, `RESP_OKAY);
      rd(ad(`IDX_LANE_CD_HI), {ed[5:4], ec}, `RESP_OKAY);
      check("lanes", {la, lb, lc, ld}, {8'h00, ea, eb, ec, ed});
    end
    // Unmapped place.
    wr(12'h004, 8'h5A, `RESP_SLVERR);
    rd(12'h004, 8'h00, `RESP_SLVERR);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule // tb
